/* File: inc/cfsc_pkg.sv */
// Package for the codec frame pulse and serial chain port.
// Assumes a 10 MHz system clock and an APB register bus.
package cfsc_pkg;
   // Register byte addresses
   localparam logic [7:0] CTRL1_OFS = 8'h04;
   localparam logic [7:0] CTRL2_OFS = 8'h08;
   localparam logic [7:0] CTRL3_OFS = 8'h0C;
   localparam logic [7:0] STAT_OFS = 8'h10;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Field positions
   localparam int C1_WORD16_BIT = 0;
   localparam int C1_SRC_LSB = 4;
   localparam int C2_FSD_OFF_BIT = 2;
   // Delay field limits
   localparam logic [5:0] DLY_ZERO_MAX = 6'h11;
   localparam logic [5:0] DLY_RED_MIN = 6'h09;
   // Frame layout in shift-clock cycles
   localparam logic [7:0] WORD_LEN = 8'h10;
   localparam logic [7:0] SEC_POS = 8'h80;
   localparam logic [7:0] POS_RST = 8'hFF;
   localparam logic [3:0] BIT_LAST = 4'hF;
   // Timing
   localparam int SYS_PERIOD_NS = 100;
   localparam int SCLK_PERIOD_NS = 800;
   localparam int QTR_NS = SCLK_PERIOD_NS / 4;
   localparam int SCLK_DIV = SCLK_PERIOD_NS / SYS_PERIOD_NS;
   localparam int QTR_RAW = QTR_NS / SYS_PERIOD_NS;
   localparam int QTR_CYC = (QTR_RAW < 1) ? 1 : QTR_RAW;
   localparam logic [3:0] PH_LAST = 4'(SCLK_DIV - 1);
   localparam logic [3:0] PH_FALL = 4'(SCLK_DIV / 2 - 1);
   localparam logic [3:0] PH_QTR = 4'(SCLK_DIV - 1 - QTR_CYC);
   localparam logic [3:0] PH_HALF = 4'(SCLK_DIV / 2);

   typedef enum logic [1:0] {
      XF_IDLE = 2'b00,
      XF_PRIM = 2'b01,
      XF_SEC = 2'b10
   } cfsc_xfer_t;

   typedef struct packed {
      logic [1:0] slaves;
      logic [5:0] delay;
   } cfsc_cfg3_t;

   typedef struct packed {
      logic valid;
      logic sec;
      logic [15:0] data;
   } cfsc_word_t;
endpackage

/* File: core/cfsc_sync.sv */
// Two-stage synchroniser, one stage pair per bit.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module cfsc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            meta[i] <= INIT[i];
            q_o[i] <= INIT[i];
         end else begin
            meta[i] <= d_i[i];
            q_o[i] <= meta[i];
         end
      end
   end
endmodule // cfsc_sync
`default_nettype wire

/* File: core/cfsc_port.sv */
// Serial data port and frame pulse chain of a master/slave voice codec.
// Assumes APB from the host; link pins arrive asynchronously and
// are resynchronised; shift clock is an input in slave mode.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Function
// - slave times transfers from frame pulse input
// - master zero delay: quarter clock early
// - master delay above 17 counts shift clocks
// - delay 1 to 17 acts as zero
// - slave zero delay: follows incoming pulse
// - slave delay above 17 counts shift clocks
// - delay held in control3 bits 0-5
// - reduced variant: one slave at most
// - reduced variant: control2 bit2 disables
// - reduced variant doubles delay count
// - shared input until control3 programmed
// - own time slot once programmed
// - primary every frame, secondary on request
// - request by pin or, in 15-bit mode, input bit 0
// - control1 bit0 word length, 15-bit default
// - 16-bit mode all bits to converter
// - 16-bit word each way per frame
// - control1 bits 4-5 select inputs
// - slave output hidden until slaves nonzero
// - master frame pulse per slot and slave
// - frame equals 256 shift clocks
module cfsc_port #(
   parameter bit REDUCED = 1'b0,
   parameter int MAX_SLAVES = 3
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic ms_mode_i,
   input wire logic sclk_i,
   output logic sclk_o,
   output logic sclk_oe_o,
   input wire logic frame_pulse_i,
   output logic frame_pulse_o,
   output logic frame_pulse_oe_o,
   output logic delayed_frame_pulse_o,
   input wire logic din_i,
   output logic dout_o,
   output logic dout_oe_o,
   input wire logic hw_secondary_request_i,
   input wire logic [15:0] adc_word_i,
   input wire logic [15:0] sec_tx_word_i,
   output cfsc_pkg::cfsc_word_t rx_o,
   output logic [1:0] src_sel_o
);
   import cfsc_pkg::*;

   if (MAX_SLAVES < 1 || MAX_SLAVES > 3) begin : g_bad_slaves
      $error("MAX_SLAVES must be 1 to 3");
   end
   if (SCLK_DIV < 4 || SCLK_DIV > 16) begin : g_bad_div
      $error("shift clock divider out of range");
   end

   logic [7:0] ctrl1;
   logic [7:0] ctrl2;
   cfsc_cfg3_t ctrl3;
   logic master, sclk_s, fs_s, din_s, hwreq_s;
   logic sclk_d, fs_prev;
   logic [3:0] ph;
   logic [7:0] pos;
   logic sec_frm;
   cfsc_xfer_t st;
   logic [3:0] bit_cnt;
   logic [15:0] tx_sh;
   logic [15:0] rx_sh;
   logic dly_on;
   logic [6:0] dly_cnt;
   logic [3:0] hold;
   logic rise, fall, qtr, own_start, done, prim_end, req_now;
   logic word16, fsd_off, zero_mode, dout_en;
   logic [6:0] m_eff;
   logic [1:0] n_eff;
   logic [7:0] pos_nx;

   cfsc_sync #(.W(5), .INIT(5'h06)) u_sync (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .d_i({ms_mode_i, sclk_i, frame_pulse_i, din_i,
            hw_secondary_request_i}),
      .q_o({master, sclk_s, fs_s, din_s, hwreq_s})
   );

   // APB slave, no wait state: answer in the first access cycle
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= psel_i && !penable_i;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         if (psel_i && !penable_i) begin
            case (paddr_i)
               CTRL1_OFS: prdata_o <= {24'h000000, ctrl1};
               CTRL2_OFS: prdata_o <= {24'h000000, ctrl2};
               CTRL3_OFS: prdata_o <= {24'h000000, ctrl3};
               STAT_OFS: prdata_o <= {24'h000000, st, sec_frm, master,
                                      zero_mode, delayed_frame_pulse_o,
                                      frame_pulse_o, dout_oe_o};
               default: pslverr_o <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl1 <= CTRL_RST;
         ctrl2 <= CTRL_RST;
         ctrl3 <= CTRL_RST;
      end else if (psel_i && penable_i && pready_o && pwrite_i) begin
         case (paddr_i)
            CTRL1_OFS: ctrl1 <= pwdata_i[7:0];
            CTRL2_OFS: ctrl2 <= pwdata_i[7:0];
            CTRL3_OFS: ctrl3 <= pwdata_i[7:0];
            default: ;
         endcase
      end
   end

   assign src_sel_o = ctrl1[C1_SRC_LSB +: 2];
   assign word16 = ctrl1[C1_WORD16_BIT];
   assign fsd_off = REDUCED && ctrl2[C2_FSD_OFF_BIT];

   always_comb begin
      m_eff = {1'b0, ctrl3.delay};
      if (REDUCED)
         m_eff = (ctrl3.delay < DLY_RED_MIN) ? 7'h00 : {ctrl3.delay, 1'b0};
      else if (ctrl3.delay <= DLY_ZERO_MAX)
         m_eff = 7'h00;
      n_eff = ctrl3.slaves;
      if (REDUCED && ctrl3.slaves != 2'b00)
         n_eff = 2'b01;
      else if (int'(ctrl3.slaves) > MAX_SLAVES)
         n_eff = 2'(MAX_SLAVES);
   end
   assign zero_mode = (m_eff == 7'h00);
   // slave output waits for slave count
   assign dout_en = master || (ctrl3.slaves != 2'b00);

   function automatic logic slot_hit(input logic [7:0] p,
                                     input logic s,
                                     input logic [6:0] m,
                                     input logic [1:0] n);
      logic hit;
      logic [7:0] b;
      hit = 1'b0;
      b = 8'h00;
      for (int k = 0; k < 4; k++) begin
         b = 8'(k * int'(m));
         if (k <= int'(n) && (k == 0 || m != 7'h00)) begin
            if (8'(p - b) < WORD_LEN)
               hit = 1'b1;
            if (s && 8'(p - b - SEC_POS) < WORD_LEN)
               hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // Master shift clock divider; slave edges from the synced pin
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ph <= 4'h0;
         sclk_o <= 1'b1;
         // Set high though the synchroniser resets sclk low: a slave sees one fall after reset
         sclk_d <= 1'b1;
      end else begin
         ph <= (ph == PH_LAST) ? 4'h0 : ph + 4'h1;
         sclk_o <= (ph == PH_LAST) || (ph + 4'h1 < PH_HALF);
         sclk_d <= sclk_s;
      end
   end

   assign rise = master ? (ph == PH_LAST) : (sclk_s && !sclk_d);
   assign fall = master ? (ph == PH_FALL) : (!sclk_s && sclk_d);
   assign qtr = master && (ph == PH_QTR);
   assign pos_nx = pos + 8'h01;

   always_comb begin
      if (master)
         own_start = rise && st == XF_IDLE &&
                     (pos_nx == 8'h00 || (pos_nx == SEC_POS && sec_frm));
      else
         own_start = rise && st == XF_IDLE && !fs_s && fs_prev;
   end
   assign done = rise && st != XF_IDLE && bit_cnt == BIT_LAST;
   assign prim_end = done && st == XF_PRIM;
   assign req_now = hwreq_s || (!word16 && rx_sh[0]);

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pos <= POS_RST;
         fs_prev <= 1'b1;
         frame_pulse_o <= 1'b1;
         frame_pulse_oe_o <= 1'b0;
         sclk_oe_o <= 1'b0;
      end else begin
         frame_pulse_oe_o <= master;
         sclk_oe_o <= master;
         if (rise) begin
            pos <= pos_nx;
            fs_prev <= fs_s;
            frame_pulse_o <= !(master &&
                               slot_hit(pos_nx, sec_frm, m_eff, n_eff));
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         sec_frm <= 1'b0;
      else if (prim_end && req_now)
         sec_frm <= 1'b1;
      else if (master && rise && pos_nx == 8'h00)
         sec_frm <= 1'b0;
      else if (!master && done && st == XF_SEC)
         sec_frm <= 1'b0;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st <= XF_IDLE;
         bit_cnt <= 4'h0;
         tx_sh <= 16'h0000;
         rx_sh <= 16'h0000;
         dout_o <= 1'b0;
         dout_oe_o <= 1'b0;
         rx_o <= '0;
      end else begin
         rx_o.valid <= 1'b0;
         if (fall && st != XF_IDLE)
            rx_sh <= {rx_sh[14:0], din_s};
         case (st)
            XF_IDLE: begin
               if (own_start) begin
                  st <= sec_frm ? XF_SEC : XF_PRIM;
                  tx_sh <= sec_frm ? sec_tx_word_i : adc_word_i;
                  dout_o <= sec_frm ? sec_tx_word_i[15] : adc_word_i[15];
                  bit_cnt <= 4'h0;
                  dout_oe_o <= dout_en;
               end
            end
            XF_PRIM, XF_SEC: begin
               if (done) begin
                  st <= XF_IDLE;
                  dout_oe_o <= 1'b0;
                  rx_o.valid <= 1'b1;
                  rx_o.sec <= (st == XF_SEC);
                  rx_o.data <= (st == XF_PRIM && !word16) ?
                               {rx_sh[15:1], 1'b0} : rx_sh;
               end else if (rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
                  tx_sh <= {tx_sh[14:0], 1'b0};
                  dout_o <= tx_sh[14];
               end
               if (!dout_en)
                  dout_oe_o <= 1'b0;
            end
            default: st <= XF_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         delayed_frame_pulse_o <= 1'b1;
         dly_on <= 1'b0;
         dly_cnt <= 7'h00;
         hold <= 4'h0;
      end else if (fsd_off) begin
         delayed_frame_pulse_o <= 1'b1;
         dly_on <= 1'b0;
      end else if (zero_mode) begin
         dly_on <= 1'b0;
         if (master && qtr)
            delayed_frame_pulse_o <= !slot_hit(pos_nx, sec_frm,
                                               7'h00, 2'b00);
         else if (!master)
            delayed_frame_pulse_o <= fs_s;
      end else if (rise) begin
         if (own_start) begin
            dly_on <= 1'b1;
            dly_cnt <= 7'h00;
         end else if (dly_on) begin
            dly_cnt <= dly_cnt + 7'h01;
            if (dly_cnt + 7'h01 == m_eff) begin
               delayed_frame_pulse_o <= 1'b0;
               hold <= BIT_LAST;
               dly_on <= 1'b0;
            end
         end
         if (!delayed_frame_pulse_o) begin
            if (hold == 4'h0)
               delayed_frame_pulse_o <= 1'b1;
            else
               hold <= hold - 4'h1;
         end
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence own_go;
      master && own_start;
   endsequence

   sequence busy8;
      (st != XF_IDLE)[*8];
   endsequence

   slave_hiz_a: assert property (
      $past(!dout_en) |-> !dout_oe_o)
      else $error("serial output driven without slave count");
   frame_fall_a: assert property (
      master && rise && pos == POS_RST |=> (!frame_pulse_o)[*8])
      else $error("frame pulse not low at frame start");
   pos_step_a: assert property (
      master && rise |=> pos == $past(pos) + 8'h01)
      else $error("frame position did not advance");
   dly_fire_a: assert property (
      dly_on && rise && !fsd_off && !zero_mode && !own_start &&
      dly_cnt + 7'h01 == m_eff |=> !delayed_frame_pulse_o)
      else $error("delayed pulse missed its count");
   zero_qtr_a: assert property (
      master && zero_mode && !fsd_off && qtr && pos == POS_RST
      |=> !delayed_frame_pulse_o ##2 !frame_pulse_o)
      else $error("delayed pulse not a quarter clock early");
   zero_band_a: assert property (
      !REDUCED && master && ctrl3.delay <= DLY_ZERO_MAX && qtr &&
      pos == POS_RST |=> !delayed_frame_pulse_o)
      else $error("low delay value not treated as zero");
   red_double_a: assert property (
      REDUCED && ctrl3.delay >= DLY_RED_MIN
      |-> m_eff == {ctrl3.delay, 1'b0})
      else $error("reduced delay not doubled");
   red_one_a: assert property (
      REDUCED |-> n_eff <= 2'b01)
      else $error("reduced variant allows more slaves");
   fsd_off_a: assert property (
      $past(fsd_off) && fsd_off |-> delayed_frame_pulse_o)
      else $error("disabled delayed pulse went low");
   xfer_len_a: assert property (
      own_go |=> busy8 ##[100:130] rx_o.valid)
      else $error("transfer length wrong");
   sec_req_a: assert property (
      prim_end && req_now |=> sec_frm)
      else $error("secondary request lost");
endmodule // cfsc_port
`default_nettype wire

/* File: test/cfsc_host_model.sv */
// Host serial port model: sends one word per frame on din, captures dout.
// Assumes the device makes the shift clock in master mode; in slave mode
// this model makes the clock and the frame pulse as the chain master.
`timescale 1ns/1ns
`default_nettype none
module cfsc_host_model (
   input wire logic ms_mode_i,
   input wire logic dev_sclk_i,
   input wire logic dev_frame_i,
   input wire logic dout_i,
   input wire logic dout_oe_i,
   input wire logic [15:0] tx_word_i,
   output logic sclk_o,
   output logic frame_o,
   output logic din_o,
   output logic [15:0] rx_word_o
);
   logic sck;
   logic fr;
   logic [7:0] pos;
   int idx;
   assign sck = ms_mode_i ? dev_sclk_i : sclk_o;
   assign fr = ms_mode_i ? dev_frame_i : frame_o;
   initial begin
      sclk_o = 1'b0;
      frame_o = 1'b1;
      din_o = 1'b0;
      rx_word_o = 16'h0000;
      pos = 8'hFF;
      idx = 0;
      // Odd offset keeps the link clock unrelated in phase to sys_clk
      #37;
      forever #400 sclk_o = ~sclk_o;
   end
   // pulse into next frame input, 256 clocks a frame
   always @(posedge sclk_o) begin
      pos <= pos + 8'h01;
      frame_o <= (8'(pos + 8'h01) > 8'h0F);
   end
   // Released din toggles so a stale level never passes for data
   always @(posedge sck) begin
      #50;
      if (fr === 1'b0 && idx < 16) din_o = tx_word_i[15 - idx];
      else din_o = ~din_o;
   end
   always @(negedge sck) begin
      if (fr === 1'b0 && idx < 16) begin
         rx_word_o[15 - idx] <= (dout_oe_i === 1'b1) ? dout_i : 1'bx;
         idx <= idx + 1;
      end else if (fr !== 1'b0) begin
         idx <= 0;
      end
   end
endmodule // cfsc_host_model
`default_nettype wire

/* File: test/cfsc_port_bench.sv */
// Bench: register table over APB, master transfers, delays, slave run.
// Assumes the host model as link partner; APB calls wait for pready.
`timescale 1ns/1ns
`default_nettype none
module cfsc_port_bench;
   import cfsc_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] w;
      logic [31:0] r;
      logic e;
   } cfsc_row_t;
   cfsc_row_t rows [4] = '{'{CTRL1_OFS, 32'h31, 32'h31, 1'b0},
      '{CTRL3_OFS, 32'hD5, 32'hD5, 1'b0}, '{8'h20, 32'hFF, 32'h0, 1'b1},
      '{CTRL1_OFS, 32'hFFFFFF00, 32'h0, 1'b0}};
   // delays used are zero or at least 9
   logic [7:0] dly_val [4] = '{8'h00, 8'h11, 8'h12, 8'h14};
   logic sys_clk_i, rst_b_i, psel, penable, pwrite, ms_mode, hw_req, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata_o, rd;
   logic pready_o, pslverr_o, sclk_o, sclk_oe_o, frame_pulse_o, p_fs, p_fsd;
   logic frame_pulse_oe_o, delayed_frame_pulse_o, dout_o, dout_oe_o;
   logic m_sclk, m_frame, m_din;
   logic fs_ref;
   logic [15:0] adc_word, sec_word, tx_word, m_rx, prim_data, prim_dout;
   logic [1:0] src_sel_o;
   cfsc_word_t rx_o;
   int num_errors, compares, cyc, t_fs, per, dly, n_prim, n_sec, oe_seen;
   int s, m;
   cfsc_port u_cfsc_port (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .ms_mode_i(ms_mode),
      .sclk_i(m_sclk), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
      .frame_pulse_i(m_frame), .frame_pulse_o(frame_pulse_o),
      .frame_pulse_oe_o(frame_pulse_oe_o),
      .delayed_frame_pulse_o(delayed_frame_pulse_o), .din_i(m_din),
      .dout_o(dout_o), .dout_oe_o(dout_oe_o),
      .hw_secondary_request_i(hw_req), .adc_word_i(adc_word),
      .sec_tx_word_i(sec_word), .rx_o(rx_o), .src_sel_o(src_sel_o));
   cfsc_host_model u_cfsc_host_model (.ms_mode_i(ms_mode),
      .dev_sclk_i(sclk_o), .dev_frame_i(frame_pulse_o), .dout_i(dout_o),
      .dout_oe_i(dout_oe_o), .tx_word_i(tx_word), .sclk_o(m_sclk),
      .frame_o(m_frame), .din_o(m_din), .rx_word_o(m_rx));
   // Frame reference: own pulse as master, chain master's pulse as slave
   assign fs_ref = ms_mode ? frame_pulse_o : m_frame;
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   task automatic tally_and_finish();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] w);
      @(posedge sys_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= w;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      @(posedge sys_clk_i);
      while (pready_o !== 1'b1) @(posedge sys_clk_i);
      rd = prdata_o;
      err = pslverr_o;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_prim(input int n);
      int k;
      k = n_prim + n;
      while (n_prim < k) @(posedge sys_clk_i);
   endtask
   task automatic do_reset(input logic md);
      rst_b_i <= 1'b0;
      ms_mode <= md;
      repeat (6) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
   endtask
   // Edge times are taken one cycle late for both pulses alike
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      p_fs <= fs_ref;
      p_fsd <= delayed_frame_pulse_o;
      if (p_fs === 1'b1 && fs_ref === 1'b0) begin
         t_fs <= cyc;
         per <= cyc - t_fs;
      end
      if (p_fsd === 1'b1 && delayed_frame_pulse_o === 1'b0) dly <= cyc - t_fs;
      if (dout_oe_o === 1'b1) oe_seen <= 1;
      if (rx_o.valid === 1'b1 && rx_o.sec === 1'b1) n_sec <= n_sec + 1;
      if (rx_o.valid === 1'b1 && rx_o.sec === 1'b0) begin
         n_prim <= n_prim + 1;
         prim_data <= rx_o.data;
         prim_dout <= m_rx;
      end
      if (cyc == 80000) begin
         num_errors = num_errors + 1;
         tally_and_finish();
      end
   end
   initial begin
      rst_b_i = 1'b0;
      {psel, penable, pwrite, hw_req} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ms_mode = 1'b1;
      adc_word = 16'hA5C3;
      sec_word = 16'h5A3C;
      tx_word = 16'h1235;
      {num_errors, compares, cyc, t_fs, per, dly, n_prim, n_sec} = '0;
      oe_seen = 0;
      do_reset(1'b1);
      @(posedge sys_clk_i);
      chk("delayed idle", delayed_frame_pulse_o, 32'h1);
      chk("src reset", src_sel_o, 32'h0);
      apb(1'b0, CTRL1_OFS, 32'h0);
      chk("ctrl1 reset", rd, 32'h0);
      apb(1'b0, CTRL3_OFS, 32'h0);
      chk("ctrl3 reset", rd, 32'h0);
      chk("oe master", {sclk_oe_o, frame_pulse_oe_o}, 32'h3);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].w);
         chk("slverr", err, rows[i].e);
         apb(1'b0, rows[i].a, 32'h0);
         chk("readback", rd, rows[i].r);
         if (i == 0) chk("src sel", src_sel_o, 32'h3);
      end
      apb(1'b1, CTRL3_OFS, 32'h0);
      wait_prim(2);
      chk("dout word", prim_dout, adc_word);
      chk("din 15 bit", prim_data, 16'h1234);
      chk("soft request", n_sec > 0, 32'h1);
      tx_word <= 16'h1234;
      wait_prim(2);
      s = n_sec;
      wait_prim(2);
      chk("no request", n_sec == s, 32'h1);
      apb(1'b1, CTRL1_OFS, 32'h1);
      tx_word <= 16'h1235;
      wait_prim(1);
      s = n_sec;
      wait_prim(2);
      chk("din 16 bit", prim_data, 16'h1235);
      chk("bit0 no request", n_sec == s, 32'h1);
      hw_req <= 1'b1;
      wait_prim(1);
      hw_req <= 1'b0;
      wait_prim(2);
      chk("hw request", n_sec > s, 32'h1);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, CTRL3_OFS, {24'h0, dly_val[i]});
         wait_prim(2);
         m = int'(dly_val[i][5:0]);
         chk("delay", dly, (m > 17) ? m * SCLK_DIV
            : 256 * SCLK_DIV - QTR_CYC);
      end
      chk("frame period", per, 256 * SCLK_DIV);
      apb(1'b1, CTRL3_OFS, 32'h54);
      wait_prim(2);
      chk("slave slot", per, (256 - 20) * SCLK_DIV);
      // Even word: din bit 0 is clear, so the slave device raises no secondary request
      tx_word <= 16'h1234;
      // delayed pulse of the last device feeds nothing
      do_reset(1'b0);
      oe_seen <= 0;
      wait_prim(2);
      chk("slave hidden", oe_seen, 32'h0);
      chk("oe slave", {sclk_oe_o, frame_pulse_oe_o}, 32'h0);
      apb(1'b1, CTRL3_OFS, 32'h40);
      wait_prim(2);
      chk("slave dout", prim_dout, adc_word);
      chk("slave zero", dly <= 4, 32'h1);
      apb(1'b1, CTRL3_OFS, 32'h54);
      wait_prim(2);
      // Pin synchronisers add a few system cycles to the slave delay
      m = dly - 20 * SCLK_DIV;
      chk("slave delay", m >= 0 && m <= 4, 32'h1);
      tally_and_finish();
   end
endmodule // cfsc_port_bench
`default_nettype wire
